// ===== verilog/acm_engine.sv
// counter-mode and cbc-mac security instruction engine over on-chip ram
//
// Decided for this implementation: the address-and-strobe port and the address map.
`timescale 1ns/1ps

module acm_engine #(
   parameter int RAM_BYTES = 1024
) (
   input  wire logic                  clk,
   input  wire logic                  srst,
   input  wire logic                  cmd_valid,
   input  wire acm_pkg::acm_cmd_t     cmd,
   input  wire logic [1:0]            reg_addr,
   input  wire logic [7:0]            reg_wdata,
   input  wire logic                  reg_wr,
   input  wire logic                  reg_rd,
   output logic      [7:0]            reg_rdata,
   output acm_pkg::acm_ram_req_t      ram_req,
   input  wire logic [7:0]            ram_rdata,
   output logic                       irq
);
   import acm_pkg::*;

   if (RAM_BYTES < BLK || RAM_BYTES > 4096)
   begin : g_size_check
      $error("ram size out of range for 12-bit addressing");
   end

   localparam logic [12:0] RAM_TOP = 13'(RAM_BYTES);

   acm_state_t        s;
   acm_state_t        next_s;
   logic [127:0]      aes_out;
   logic              aes_done;
   logic [ST_W-1:0]   ev;
   logic [ST_W-1:0]   clr;
   logic [1:0]        busy;
   acm_cmd_t          c;
   logic              p;
   logic [4:0]        j;
   logic [7:0]        sp;
   logic [7:0]        sb;
   logic [7:0]        nbytes;
   logic [11:0]       wbase;

   function automatic logic [7:0] get_b(input logic [127:0] blk,
                                        input logic [4:0]   i);
      return blk[(15 - i) * 8 +: 8];
   endfunction

   function automatic logic [127:0] put_b(input logic [127:0] blk,
                                          input logic [4:0]   i,
                                          input logic [7:0]   b);
      logic [127:0] o;
      o = blk;
      o[(15 - i) * 8 +: 8] = b;
      return o;
   endfunction

   function automatic logic is_mac(input acm_cmd_t x);
      return x.op == mac_generate_op;
   endfunction

   function automatic logic [4:0] mac_len(input logic [1:0] m);
      case (m)
         2'h1:    return 5'h04;
         2'h2:    return 5'h08;
         2'h3:    return 5'h10;
         default: return 5'h00;
      endcase
   endfunction

   // length prefix used only by the mac op with bit 2 clear
   function automatic logic has_pre(input acm_cmd_t x);
      return is_mac(x) && !x.mac[2];
   endfunction

   function automatic logic [7:0] stream_len(input acm_cmd_t x);
      return {1'b0, x.cnt} + {7'h00, has_pre(x)};
   endfunction

   function automatic logic [11:0] out_base(input acm_cmd_t x);
      if (x.dst != 12'h000)
         return x.dst;
      else if (is_mac(x))
         return x.src + {5'h00, x.cnt};
      else
         return x.src;
   endfunction

   function automatic logic [7:0] out_len(input acm_cmd_t x);
      return is_mac(x) ? {3'h0, mac_len(x.mac[1:0])} : {1'b0, x.cnt};
   endfunction

   function automatic logic range_bad(input acm_cmd_t x);
      logic [12:0] k_end;
      logic [12:0] n_end;
      logic [12:0] s_end;
      logic [12:0] d_end;
      k_end = {1'b0, x.key, 4'h0} + BLK_SPAN;
      n_end = {1'b0, x.ctr, 4'h0} + BLK_SPAN;
      s_end = {1'b0, x.src} + {6'h00, x.cnt};
      d_end = {1'b0, out_base(x)} + {5'h00, out_len(x)};
      return (k_end > RAM_TOP) || (!is_mac(x) && n_end > RAM_TOP)
         || (s_end > RAM_TOP) || (d_end > RAM_TOP);
   endfunction

   // data byte at stream position q comes from ram unless padding or prefix
   function automatic logic from_ram(input acm_cmd_t x,
                                     input logic [7:0] q);
      return q < stream_len(x) && !(has_pre(x) && q == 8'h00);
   endfunction

   acm_aes_core u_aes (
      .clk   (clk),
      .srst  (srst),
      .start (s.aes_go),
      .key   (s.key),
      .din   (is_mac(s.cur) ? s.acc : s.ctr),
      .dout  (aes_out),
      .done  (aes_done)
   );

   always_comb
   begin
      next_s = s;
      ev = '0;
      c = s.cur;
      p = 1'b0;
      j = 5'h00;
      sp = 8'h00;
      sb = 8'h00;
      next_s.ram.we = 1'b0;
      next_s.ram.re = 1'b0;
      next_s.aes_go = 1'b0;
      next_s.rdata = 8'h00;
      busy[0] = s.pend_v[0] || (s.run && !s.cur.prio);
      busy[1] = s.pend_v[1] || (s.run && s.cur.prio);
      nbytes = out_len(s.cur) - (is_mac(s.cur) ? 8'h00 : s.pos);
      if (!is_mac(s.cur) && nbytes > BLK_STEP)
         nbytes = BLK_STEP;
      wbase = out_base(s.cur) + (is_mac(s.cur) ? 12'h000 : {4'h0, s.pos});

      // register reads
      if (reg_rd)
      begin
         case (reg_addr)
            REG_STATUS: next_s.rdata = {3'h0, s.status};
            REG_MASK:   next_s.rdata = {3'h0, s.mask};
            REG_BUSY:   next_s.rdata = {6'h00, busy};
            default:    next_s.rdata = 8'h00;
         endcase
      end
      if (reg_wr && reg_addr == REG_MASK)
         next_s.mask = reg_wdata[ST_W-1:0];

      // instruction intake, one slot per priority level
      if (cmd_valid)
      begin
         if (busy[cmd.prio])
            ev[ST_BUSY] = 1'b1;
         else
         begin
            next_s.pend[cmd.prio] = cmd;
            next_s.pend_v[cmd.prio] = 1'b1;
         end
      end

      case (s.ph)
         ph_idle:
         begin
            if (|s.pend_v)
            begin
               p = s.pend_v[1];
               c = s.pend[p];
               next_s.pend_v[p] = 1'b0;
               next_s.cur = c;
               if (c.op == op_unused)
               begin
                  ev[ST_OPERAND] = 1'b1;
                  ev[c.prio ? ST_HIGH_DONE : ST_LOW_DONE] = 1'b1;
               end
               else if (range_bad(c))
               begin
                  ev[ST_RANGE] = 1'b1;
                  ev[c.prio ? ST_HIGH_DONE : ST_LOW_DONE] = 1'b1;
               end
               else
               begin
                  next_s.run = 1'b1;
                  next_s.ph = ph_load;
                  next_s.tgt = tg_key;
                  next_s.idx = 5'h00;
                  next_s.pos = 8'h00;
                  next_s.acc = '0;
               end
            end
         end

         // one read per cycle, data captured the cycle after
         ph_load:
         begin
            if (s.idx < BLK_LAST)
            begin
               sp = s.pos + {3'h0, s.idx};
               case (s.tgt)
                  tg_key:
                  begin
                     next_s.ram.re = 1'b1;
                     next_s.ram.addr = {c.key, 4'h0} + {7'h00, s.idx};
                  end
                  tg_ctr:
                  begin
                     next_s.ram.re = 1'b1;
                     next_s.ram.addr = {c.ctr, 4'h0} + {7'h00, s.idx};
                  end
                  default:
                  begin
                     next_s.ram.re = from_ram(c, sp);
                     next_s.ram.addr = c.src + {4'h0, sp}
                        - {11'h000, has_pre(c)};
                  end
               endcase
            end
            if (s.idx != 5'h00)
            begin
               j = s.idx - 5'h01;
               sp = s.pos + {3'h0, j};
               case (s.tgt)
                  tg_key:  next_s.key = put_b(s.key, j, ram_rdata);
                  tg_ctr:  next_s.ctr = put_b(s.ctr, j, ram_rdata);
                  default:
                  begin
                     if (from_ram(c, sp))
                        sb = ram_rdata;
                     else if (has_pre(c) && sp == 8'h00)
                        sb = {1'b0, c.cnt};
                     else
                        sb = 8'h00;
                     next_s.acc = put_b(s.acc, j, get_b(s.acc, j) ^ sb);
                  end
               endcase
            end
            next_s.idx = s.idx + 5'h01;
            if (s.idx == BLK_LAST)
            begin
               next_s.idx = 5'h00;
               case (s.tgt)
                  tg_key:  next_s.tgt = is_mac(c) ? tg_data : tg_ctr;
                  tg_ctr:  next_s.ph = ph_aes;
                  default: next_s.ph = is_mac(c) ? ph_aes : ph_write;
               endcase
            end
         end

         ph_aes:
         begin
            next_s.aes_go = 1'b1;
            next_s.ph = ph_wait;
         end

         ph_wait:
         begin
            if (aes_done)
            begin
               next_s.acc = aes_out;
               next_s.idx = 5'h00;
               if (!is_mac(c))
               begin
                  next_s.ph = ph_load;
                  next_s.tgt = tg_data;
               end
               else
               begin
                  next_s.pos = s.pos + BLK_STEP;
                  if (s.pos + BLK_STEP < stream_len(c))
                  begin
                     next_s.ph = ph_load;
                     next_s.tgt = tg_data;
                  end
                  else
                     next_s.ph = ph_write;
               end
            end
         end

         ph_write:
         begin
            if ({3'h0, s.idx} < nbytes)
            begin
               next_s.ram.we = 1'b1;
               next_s.ram.addr = wbase + {7'h00, s.idx};
               next_s.ram.wdata = get_b(s.acc, s.idx);
               next_s.idx = s.idx + 5'h01;
            end
            else if (!is_mac(c) && s.pos + BLK_STEP < {1'b0, c.cnt})
            begin
               next_s.pos = s.pos + BLK_STEP;
               next_s.ctr[15:0] = s.ctr[15:0] + CTR_STEP;
               next_s.acc = '0;
               next_s.ph = ph_aes;
            end
            else
            begin
               next_s.run = 1'b0;
               next_s.ph = ph_idle;
               ev[c.prio ? ST_HIGH_DONE : ST_LOW_DONE] = 1'b1;
            end
         end

         default:
         begin
            next_s.ph = ph_idle;
            next_s.run = 1'b0;
         end
      endcase

      // sticky status, a new event wins over a same-cycle clear
      clr = (reg_wr && reg_addr == REG_STATUS) ? reg_wdata[ST_W-1:0] : '0;
      next_s.status = (s.status & ~clr) | ev;
      next_s.irq = |(next_s.status & next_s.mask);
   end

   always_ff @(posedge clk)
   begin
      if (srst)
      begin
         s <= '0;
         s.status <= STATUS_RST;
         s.mask <= MASK_RST;
         s.ph <= ph_idle;
         s.tgt <= tg_key;
      end
      else
         s <= next_s;
   end

   assign reg_rdata = s.rdata;
   assign ram_req = s.ram;
   assign irq = s.irq;

endmodule // acm_engine

// ===== include/acm_pkg.sv
// shared types and constants of the counter / cbc-mac security engine
package acm_pkg;

   localparam int AW       = 12;
   localparam int CW       = 7;
   localparam int BLK      = 16;
   localparam int ST_W     = 5;

   // register offsets on the plain register port
   localparam logic [1:0] REG_STATUS = 2'h0;
   localparam logic [1:0] REG_MASK   = 2'h1;
   localparam logic [1:0] REG_BUSY   = 2'h2;

   // status / mask bit positions
   localparam int ST_LOW_DONE  = 0;
   localparam int ST_HIGH_DONE = 1;
   localparam int ST_BUSY      = 2;
   localparam int ST_RANGE     = 3;
   localparam int ST_OPERAND   = 4;

   localparam logic [4:0]  STATUS_RST = 5'h00;
   localparam logic [4:0]  MASK_RST   = 5'h00;
   localparam logic [4:0]  BLK_LAST   = 5'h10;
   localparam logic [7:0]  BLK_STEP   = 8'h10;
   localparam logic [12:0] BLK_SPAN   = 13'h0010;
   localparam logic [15:0] CTR_STEP   = 16'h0001;

   // aes-128 round sequencing
   localparam logic [3:0] AES_ROUNDS = 4'ha;
   localparam logic [7:0] RCON_INIT  = 8'h01;

   typedef enum logic [1:0] {
      counter_encrypt_op,
      counter_decrypt_op,
      mac_generate_op,
      op_unused
   } acm_op_t;

   typedef struct packed {
      acm_op_t     op;
      logic        prio;
      logic [7:0]  key;
      logic [6:0]  cnt;
      logic [7:0]  ctr;
      logic [11:0] src;
      logic [11:0] dst;
      logic [2:0]  mac;
   } acm_cmd_t;

   typedef struct packed {
      logic [11:0] addr;
      logic [7:0]  wdata;
      logic        we;
      logic        re;
   } acm_ram_req_t;

   typedef enum logic [2:0] {
      ph_idle,
      ph_load,
      ph_aes,
      ph_wait,
      ph_write
   } acm_phase_t;

   typedef enum logic [1:0] {
      tg_key,
      tg_ctr,
      tg_data
   } acm_tgt_t;

   typedef struct packed {
      logic         busy;
      logic         done;
      logic [3:0]   rnd;
      logic [7:0]   rc;
      logic [127:0] st;
      logic [127:0] rk;
   } acm_aes_st_t;

   typedef struct packed {
      logic [1:0]       pend_v;
      acm_cmd_t [1:0]   pend;
      logic             run;
      acm_cmd_t         cur;
      acm_phase_t       ph;
      acm_tgt_t         tgt;
      logic [4:0]       idx;
      logic [7:0]       pos;
      logic [127:0]     key;
      logic [127:0]     ctr;
      logic [127:0]     acc;
      logic             aes_go;
      acm_ram_req_t     ram;
      logic [ST_W-1:0]  status;
      logic [ST_W-1:0]  mask;
      logic [7:0]       rdata;
      logic             irq;
   } acm_state_t;

endpackage

// ===== verilog/acm_aes_core.sv
// iterative aes-128 block encryptor, one round per clock
`timescale 1ns/1ps
module acm_aes_core (
   input  wire logic         clk,
   input  wire logic         srst,
   input  wire logic         start,
   input  wire logic [127:0] key,
   input  wire logic [127:0] din,
   output logic      [127:0] dout,
   output logic              done
);
   import acm_pkg::*;

   acm_aes_st_t s;
   acm_aes_st_t next_s;
   logic [127:0] nk;

   function automatic logic [7:0] xt(input logic [7:0] a);
      return {a[6:0], 1'b0} ^ (a[7] ? 8'h1b : 8'h00);
   endfunction

   function automatic logic [7:0] gmul(input logic [7:0] a, b);
      logic [7:0] r;
      logic [7:0] x;
      r = 8'h00;
      x = a;
      for (int i = 0; i < 8; i++)
      begin
         if (b[i])
            r = r ^ x;
         x = xt(x);
      end
      return r;
   endfunction

   // inverse as x^254, then the affine map
   function automatic logic [7:0] sbox(input logic [7:0] x);
      logic [7:0] p;
      logic [7:0] r;
      p = x;
      r = 8'h01;
      for (int i = 0; i < 7; i++)
      begin
         p = gmul(p, p);
         r = gmul(r, p);
      end
      return r ^ {r[6:0], r[7]} ^ {r[5:0], r[7:6]} ^ {r[4:0], r[7:5]}
         ^ {r[3:0], r[7:4]} ^ 8'h63;
   endfunction

   function automatic logic [127:0] expand(input logic [127:0] rk,
                                           input logic [7:0]   rc);
      logic [31:0] w0, w1, w2, w3, t;
      {w0, w1, w2, w3} = rk;
      t = {sbox(w3[23:16]) ^ rc, sbox(w3[15:8]), sbox(w3[7:0]),
           sbox(w3[31:24])};
      w0 = w0 ^ t;
      w1 = w1 ^ w0;
      w2 = w2 ^ w1;
      w3 = w3 ^ w2;
      return {w0, w1, w2, w3};
   endfunction

   function automatic logic [127:0] round(input logic [127:0] st, rk,
                                          input logic last);
      logic [7:0]   b [16];
      logic [7:0]   t [16];
      logic [127:0] o;
      for (int i = 0; i < 16; i++)
         b[i] = sbox(st[(15-i)*8 +: 8]);
      for (int i = 0; i < 16; i++)
         t[i] = b[(i % 4) + 4 * (((i / 4) + (i % 4)) % 4)];
      for (int c = 0; c < 4; c++)
      begin
         o[(15-4*c)*8 +: 8] = last ? t[4*c] : xt(t[4*c])
            ^ gmul(t[4*c+1], 8'h03) ^ t[4*c+2] ^ t[4*c+3];
         o[(14-4*c)*8 +: 8] = last ? t[4*c+1] : t[4*c] ^ xt(t[4*c+1])
            ^ gmul(t[4*c+2], 8'h03) ^ t[4*c+3];
         o[(13-4*c)*8 +: 8] = last ? t[4*c+2] : t[4*c] ^ t[4*c+1]
            ^ xt(t[4*c+2]) ^ gmul(t[4*c+3], 8'h03);
         o[(12-4*c)*8 +: 8] = last ? t[4*c+3] : gmul(t[4*c], 8'h03)
            ^ t[4*c+1] ^ t[4*c+2] ^ xt(t[4*c+3]);
      end
      return o ^ rk;
   endfunction

   always_comb
   begin
      next_s = s;
      next_s.done = 1'b0;
      nk = expand(s.rk, s.rc);
      if (start)
      begin
         next_s.busy = 1'b1;
         next_s.st = din ^ key;
         next_s.rk = key;
         next_s.rnd = 4'h1;
         next_s.rc = RCON_INIT;
      end
      else if (s.busy)
      begin
         next_s.st = round(s.st, nk, s.rnd == AES_ROUNDS);
         next_s.rk = nk;
         next_s.rc = xt(s.rc);
         next_s.rnd = s.rnd + 4'h1;
         if (s.rnd == AES_ROUNDS)
         begin
            next_s.busy = 1'b0;
            next_s.done = 1'b1;
         end
      end
   end

   always_ff @(posedge clk)
   begin
      if (srst)
         s <= '0;
      else
         s <= next_s;
   end

   assign dout = s.st;
   assign done = s.done;

endmodule // acm_aes_core

// ===== sim/acm_engine_checker.sv
// port assertions for the security engine
`timescale 1ns/1ps
module acm_engine_checker #(
   parameter int RAM_BYTES = 1024
) (
   input wire logic                  clk,
   input wire logic                  srst,
   input wire logic                  cmd_valid,
   input wire acm_pkg::acm_cmd_t     cmd,
   input wire logic [1:0]            reg_addr,
   input wire logic [7:0]            reg_wdata,
   input wire logic                  reg_wr,
   input wire logic                  reg_rd,
   input wire logic [7:0]            reg_rdata,
   input wire acm_pkg::acm_ram_req_t ram_req,
   input wire logic [7:0]            ram_rdata,
   input wire logic                  irq
);
   import acm_pkg::*;
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (srst);

   sequence s_rd_unmapped;
      reg_rd && reg_addr == 2'h3;
   endsequence
   sequence s_rd_zero;
      reg_rdata == 8'h00;
   endsequence

   a_reset_quiet: assert property (disable iff (1'b0)
      srst |=> ram_req == '0 && !irq && reg_rdata == 8'h00)
      else $error("outputs not idle after reset");
   a_rdata_idle: assert property (!reg_rd |=> s_rd_zero)
      else $error("read data outside answer cycle");
   a_unmapped_zero: assert property (s_rd_unmapped |=> s_rd_zero)
      else $error("unmapped register not zero");
   a_rdata_upper: assert property (reg_rd |=> reg_rdata[7:5] == 3'h0)
      else $error("unused register bits set");
   a_rw_exclusive: assert property (!(ram_req.re && ram_req.we))
      else $error("ram read and write together");
   a_addr_inside: assert property (
      (ram_req.re || ram_req.we) |-> ram_req.addr < RAM_BYTES)
      else $error("ram access outside ram");
   a_read_ascend: assert property (
      ram_req.re && $past(ram_req.re)
      |-> ram_req.addr == $past(ram_req.addr) + 12'h001)
      else $error("reads not consecutive");
   a_write_ascend: assert property (
      ram_req.we && $past(ram_req.we)
      |-> ram_req.addr == $past(ram_req.addr) + 12'h001)
      else $error("writes not consecutive");
endmodule // acm_engine_checker

bind acm_engine acm_engine_checker #(.RAM_BYTES(RAM_BYTES)) u_acm_chk (
   .clk(clk), .srst(srst), .cmd_valid(cmd_valid), .cmd(cmd),
   .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
   .reg_rd(reg_rd), .reg_rdata(reg_rdata), .ram_req(ram_req),
   .ram_rdata(ram_rdata), .irq(irq));

// ===== sim/acm_ram_model.sv
// byte ram beside the engine, read through the engine's request register
`timescale 1ns/1ps
module acm_ram_model (
   input  wire logic                  clk,
   input  wire acm_pkg::acm_ram_req_t req,
   output logic [7:0]                 rdata
);
   import acm_pkg::*;
   logic [7:0]  mem [0:4095];
   logic [11:0] rd_log [$];
   logic [11:0] wr_log [$];

   always @(posedge clk)
   begin
      if (req.we)
      begin
         mem[req.addr] <= req.wdata;
         wr_log.push_back(req.addr);
      end
      if (req.re)
         rd_log.push_back(req.addr);
   end

   // request is registered in the engine, so the byte answers in its cycle
   // without a read the inverse stands, so a stray capture shows up
   assign rdata = req.re ? mem[req.addr] : ~mem[req.addr];
endmodule // acm_ram_model

// ===== sim/tb_acm_engine.sv
// self-checking bench for the security engine
`timescale 1ns/1ps
module tb_acm_engine;
   import acm_pkg::*;
   localparam int RB = 256;
   logic         clk, srst, cmd_valid, reg_wr, reg_rd, irq;
   acm_cmd_t     cmd;
   logic [1:0]   reg_addr;
   logic [7:0]   reg_wdata, reg_rdata, ram_rdata, d;
   acm_ram_req_t ram_req;
   int           n_fail, compares, cyc;
   logic [127:0] tg [8];
   int           ltab [4] = '{0, 4, 8, 16};

   acm_engine #(.RAM_BYTES(RB)) uut (.clk(clk), .srst(srst),
      .cmd_valid(cmd_valid), .cmd(cmd), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
      .reg_rdata(reg_rdata), .ram_req(ram_req), .ram_rdata(ram_rdata),
      .irq(irq));
   acm_ram_model ram (.clk(clk), .req(ram_req), .rdata(ram_rdata));

   always #50 clk = ~clk;

   task automatic report_and_stop;
      if (n_fail == 0 && compares > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask

   always @(posedge clk)
   begin
      cyc++;
      if (cyc == 30000)
      begin
         n_fail++;
         report_and_stop;
      end
   end

   task automatic chk(input logic ok, input string msg);
      compares++;
      if (ok !== 1'b1)
      begin
         n_fail++;
         $display("[FAIL] %0t %s", $time, msg);
      end
   endtask

   task automatic wr(input logic [1:0] a, input logic [7:0] v);
      @(posedge clk);
      reg_wr    <= 1'b1;
      reg_addr  <= a;
      reg_wdata <= v;
      @(posedge clk);
      reg_wr    <= 1'b0;
   endtask

   task automatic rd(input logic [1:0] a);
      @(posedge clk);
      reg_rd   <= 1'b1;
      reg_addr <= a;
      @(posedge clk);
      reg_rd   <= 1'b0;
      #1 d = reg_rdata;
   endtask

   task automatic send(input acm_op_t op, input logic p, input logic [7:0] k,
      input logic [6:0] c, input logic [11:0] s, input logic [11:0] e,
      input logic [2:0] m);
      @(posedge clk);
      cmd_valid <= 1'b1;
      cmd       <= '{op, p, k, c, 8'h02, s, e, m};
      @(posedge clk);
      cmd_valid <= 1'b0;
   endtask

   task automatic wait_st(input int b);
      d = 8'h00;
      for (int i = 0; i < 1000 && d[b] !== 1'b1; i++)
         rd(REG_STATUS);
      chk(d[b] === 1'b1, "no completion flag");
   endtask

   initial
   begin
      clk = 1'b0;
      srst = 1'b1;
      cmd_valid = 1'b0;
      reg_wr = 1'b0;
      reg_rd = 1'b0;
      reg_addr = 2'h0;
      reg_wdata = 8'h00;
      cmd = '0;
      n_fail = 0;
      compares = 0;
      cyc = 0;
      for (int i = 0; i < 4096; i++)
         ram.mem[i] = i[7:0] ^ 8'h5a;
      repeat (16) @(posedge clk);
      srst <= 1'b0;
      for (int a = 0; a < 4; a++)
      begin
         rd(a[1:0]);
         chk(d === 8'h00, "reset value");
      end
      // counter encrypt across a block boundary
      send(counter_encrypt_op, 1'b0, 8'h01, 7'h14, 12'h040, 12'h080,
         3'h0);
      wait_st(ST_LOW_DONE);
      chk(ram.rd_log[0] === 12'h010, "key slot");
      chk(ram.rd_log[16] === 12'h020, "counter slot");
      chk(ram.rd_log[32] === 12'h040, "source start");
      chk(ram.wr_log.size() == 20, "output length");
      chk(ram.wr_log[0] === 12'h080, "output place");
      chk(ram.mem[148] === 8'hce, "byte beyond count");
      wr(REG_STATUS, 8'h1f);
      // decrypt in place at high level restores plaintext
      send(counter_decrypt_op, 1'b1, 8'h01, 7'h14, 12'h080, 12'h000,
         3'h0);
      wait_st(ST_HIGH_DONE);
      chk(d[ST_LOW_DONE] === 1'b0, "wrong level flag");
      for (int i = 0; i < 20; i++)
         chk(ram.mem[128 + i] === ram.mem[64 + i], "round trip");
      wr(REG_STATUS, 8'h1f);
      // mac lengths, placement and prefix
      for (int m = 0; m < 8; m++)
      begin
         ram.wr_log.delete();
         send(mac_generate_op, 1'b0, 8'h01, 7'h0a, 12'h040,
            (m == 2) ? 12'h0c8 : 12'h000, m[2:0]);
         wait_st(ST_LOW_DONE);
         wr(REG_STATUS, 8'h1f);
         chk(ram.wr_log.size() == ltab[m % 4], "tag length");
         if (m % 4 != 0)
            chk(ram.wr_log[0] === (m == 2 ? 12'h0c8 : 12'h04a), "tag");
         for (int j = 0; j < 16; j++)
            tg[m] = {tg[m][119:0], ram.mem[74 + j]};
      end
      chk(tg[1][127:96] === tg[3][127:96], "short tag not leading");
      chk(tg[3] !== tg[7], "prefix had no effect");
      // busy refusal and its interrupt
      wr(REG_MASK, 8'h04);
      send(counter_encrypt_op, 1'b0, 8'h01, 7'h14, 12'h040, 12'h080, 3'h0);
      send(counter_encrypt_op, 1'b0, 8'h01, 7'h14, 12'h040, 12'h080,
         3'h0);
      send(mac_generate_op, 1'b1, 8'h01, 7'h0a, 12'h040, 12'h000, 3'h3);
      rd(REG_BUSY);
      chk(d[1:0] === 2'h3, "both levels occupied");
      chk(irq === 1'b1, "fault interrupt");
      wait_st(ST_LOW_DONE);
      wait_st(ST_HIGH_DONE);
      chk(d[ST_BUSY] === 1'b1, "busy fault flag");
      wr(REG_STATUS, 8'h04);
      rd(REG_STATUS);
      chk(d[ST_BUSY] === 1'b0 && irq === 1'b0, "fault not cleared");
      wr(REG_MASK, 8'h00);
      wr(REG_STATUS, 8'h1f);
      // range and operand faults touch no ram
      for (int f = 0; f < 3; f++)
      begin
         ram.rd_log.delete();
         ram.wr_log.delete();
         send((f == 2) ? op_unused : counter_encrypt_op, 1'b1,
            (f == 0) ? 8'h10 : 8'h01, 7'h0a,
            (f == 1) ? 12'h0fa : 12'h040, 12'h080, 3'h0);
         wait_st(ST_HIGH_DONE);
         chk(d[f == 2 ? ST_OPERAND : ST_RANGE] === 1'b1, "fault flag");
         chk(ram.rd_log.size() + ram.wr_log.size() == 0, "access");
         wr(REG_STATUS, 8'h1f);
      end
      report_and_stop;
   end
endmodule // tb_acm_engine
